/* File: logic/pbcs_defs.vh */
// Constants for the base clock selector block
`ifndef PBCS_DEFS_VH
`define PBCS_DEFS_VH
`define PBCS_ADDR_CTRL    8'h00
`define PBCS_ADDR_MULH    8'h04
`define PBCS_ADDR_MULL    8'h08
`define PBCS_ADDR_RANGE   8'h0C
`define PBCS_ADDR_REFDIV  8'h10
`define PBCS_ADDR_STATUS  8'h14
`define PBCS_CTRL_IRQEN   7
`define PBCS_CTRL_FLAG    6
`define PBCS_CTRL_PLL_ON_A   5
`define PBCS_CTRL_BCS     4
`define PBCS_RST_PLL_ON_A    1'h1
`define PBCS_RST_MULH     4'h0
`define PBCS_RST_MULL     8'h40
`define PBCS_RST_RANGE    8'h40
`define PBCS_RST_REFDIV   4'h1
`define PBCS_FNOM_HZ      32'h00009600
`define PBCS_SWITCH_EDGES 2'h3
`endif

/* File: logic/pbcs_top.v */
// Base clock selector with PLL programming registers on APB
//
// Operation
// - zero divider or multiplier acts as one
// - zero range multiplier disables PLL, forces crystal
// - switch waits three old, three new edges
// - base clock held static during switch
// - base clock is selected source halved
// - select bit picks crystal or VCO clock
// - VCO select blocked while PLL off
// - PLL cannot turn off while VCO selected
// - PLL on and VCO select need separate writes
// - center frequency is L times 2^E times step
// - oscillator enable gates oscillator and PLL
// - stop-mode bit keeps oscillator running
// - base clock has fifty percent duty
// - interrupt output driven from lock detector
// - programming fields read-only while PLL on
`timescale 1ns/10ps
`include "pbcs_defs.vh"

module pbcs_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        crystal_clock,
  input  wire        vco_clock,
  input  wire        pll_lock,
  input  wire        osc_enable_from_sysint,
  input  wire        osc_run_in_stop,
  output wire        base_clock_out,
  output wire        osc_enable,
  output wire        pll_enable,
  output wire        clock_gen_interrupt,
  output wire [1:0]  prescaler_exp,
  output wire [1:0]  vco_range_exp,
  output wire [11:0] eff_multiplier,
  output wire [3:0]  eff_ref_divider,
  output wire [31:0] vco_center_hz
);

  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_STOP = 2'h1;
  localparam [1:0] ST_START = 2'h2;

  function [11:0] zero_as_one;
    input [11:0] val;
    begin
      zero_as_one = (val == 12'h000) ? 12'h001 : val;
    end
  endfunction

  // Register decode shared by the control write and the flag clear
  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  reg        irqen_ff;
  reg        flag_ff;
  reg        pll_on_a_ff;
  reg        base_clock_select_ff;
  reg [1:0]  pre_ff;
  reg [1:0]  vco_range_exponent_field_ff;
  reg [3:0]  multiplier_high_reg_ff;
  reg [7:0]  multiplier_low_reg_ff;
  reg [7:0]  vco_range_select_reg_ff;
  reg [3:0]  ref_divider_reg_ff;
  reg [31:0] prdata_ff;
  reg        pready_ff;
  reg        pslverr_ff;
  reg        lock_d_ff;
  reg        xclk_d_ff;
  reg        vclk_d_ff;
  reg        src_ff;
  reg [1:0]  state_ff;
  reg [1:0]  cnt_ff;
  reg        out_ff;
  reg        osc_en_ff;
  reg        pll_en_ff;
  reg        irq_ff;
  reg [11:0] eff_mul_ff;
  reg [3:0]  eff_div_ff;
  reg [31:0] center_ff;

  reg        nxt_pll_on;
  reg        nxt_bcs;
  reg [31:0] nxt_rdata;
  reg        nxt_err;
  reg [1:0]  nxt_state;
  reg [1:0]  nxt_cnt;
  reg        nxt_src;
  reg        nxt_out;

  wire        wr_done  = psel & penable & pready_ff & pwrite;
  wire        rd_done  = psel & penable & pready_ff & ~pwrite;
  wire        l_zero   = (vco_range_select_reg_ff == 8'h00);
  wire        prog_ok  = ~pll_on_a_ff;
  wire        xclk_rise = crystal_clock & ~xclk_d_ff;
  wire        vclk_rise = vco_clock & ~vclk_d_ff;
  wire        want_src = base_clock_select_ff;
  wire        old_rise = src_ff ? vclk_rise : xclk_rise;
  wire        new_rise = src_ff ? xclk_rise : vclk_rise;
  wire        lock_tgl = pll_lock ^ lock_d_ff;
  wire [11:0] raw_mul  = {multiplier_high_reg_ff, multiplier_low_reg_ff};
  // VCO counts as in use until a switch away from it has finished
  wire        switch_busy = (state_ff != ST_RUN);
  wire        vco_in_use  = src_ff | switch_busy;
  wire [11:0] div_as_one  = zero_as_one({8'h00, ref_divider_reg_ff});

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign base_clock_out      = out_ff;
  assign osc_enable          = osc_en_ff;
  assign pll_enable          = pll_en_ff;
  assign clock_gen_interrupt = irq_ff;
  assign prescaler_exp       = pre_ff;
  assign vco_range_exp       = vco_range_exponent_field_ff;
  assign eff_multiplier      = eff_mul_ff;
  assign eff_ref_divider     = eff_div_ff;
  assign vco_center_hz       = center_ff;

  // Interlocks judged against the old values, so a write changing both
  // bits moves each one only if the old values allow it, so from PLL on, VCO off both move
  // PLL stays on while the VCO still feeds the switch, or it would stall
  always @* begin
    nxt_pll_on = pll_on_a_ff;
    nxt_bcs    = base_clock_select_ff;
    if (wr_done && addr_is(paddr, `PBCS_ADDR_CTRL)) begin
      nxt_pll_on = pwdata[`PBCS_CTRL_PLL_ON_A] | base_clock_select_ff |
                   vco_in_use;
      nxt_bcs    = pwdata[`PBCS_CTRL_BCS] & pll_on_a_ff;
    end
    if (l_zero)
      nxt_bcs = 1'b0;
  end

  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err   = 1'b0;
    case (paddr)
      `PBCS_ADDR_CTRL:   nxt_rdata[7:0] = {irqen_ff, flag_ff, pll_on_a_ff,
                                           base_clock_select_ff, pre_ff,
                                           vco_range_exponent_field_ff};
      `PBCS_ADDR_MULH:   nxt_rdata[3:0] = multiplier_high_reg_ff;
      `PBCS_ADDR_MULL:   nxt_rdata[7:0] = multiplier_low_reg_ff;
      `PBCS_ADDR_RANGE:  nxt_rdata[7:0] = vco_range_select_reg_ff;
      `PBCS_ADDR_REFDIV: nxt_rdata[3:0] = ref_divider_reg_ff;
      `PBCS_ADDR_STATUS: nxt_rdata[3:0] = {pll_en_ff, src_ff,
                                           switch_busy, pll_lock};
      default:           nxt_err = 1'b1;
    endcase
  end

  // APB: one wait state, data and error answered with pready
  // Read data is zero outside its answer cycle so nothing stale leaks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & nxt_err;
      if (psel && penable && !pready_ff && !pwrite)
        prdata_ff <= nxt_rdata;
      else
        prdata_ff <= 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqen_ff                    <= 1'b0;
      flag_ff                     <= 1'b0;
      pll_on_a_ff                 <= `PBCS_RST_PLL_ON_A;
      base_clock_select_ff        <= 1'b0;
      pre_ff                      <= 2'h0;
      vco_range_exponent_field_ff <= 2'h0;
      multiplier_high_reg_ff      <= `PBCS_RST_MULH;
      multiplier_low_reg_ff       <= `PBCS_RST_MULL;
      vco_range_select_reg_ff     <= `PBCS_RST_RANGE;
      ref_divider_reg_ff          <= `PBCS_RST_REFDIV;
      lock_d_ff                   <= 1'b0;
    end else begin
      pll_on_a_ff          <= nxt_pll_on;
      base_clock_select_ff <= nxt_bcs;
      lock_d_ff            <= pll_lock;
      // Lock change wins over the read that clears the flag
      if (lock_tgl)
        flag_ff <= 1'b1;
      else if (rd_done && addr_is(paddr, `PBCS_ADDR_CTRL))
        flag_ff <= 1'b0;
      // Programming writes while the PLL runs are dropped without error
      if (wr_done) begin
        case (paddr)
          `PBCS_ADDR_CTRL: begin
            irqen_ff <= pwdata[`PBCS_CTRL_IRQEN];
            if (prog_ok) begin
              pre_ff                      <= pwdata[3:2];
              vco_range_exponent_field_ff <= pwdata[1:0];
            end
          end
          `PBCS_ADDR_MULH:
            if (prog_ok) multiplier_high_reg_ff <= pwdata[3:0];
          `PBCS_ADDR_MULL:
            if (prog_ok) multiplier_low_reg_ff <= pwdata[7:0];
          `PBCS_ADDR_RANGE:
            if (prog_ok) vco_range_select_reg_ff <= pwdata[7:0];
          `PBCS_ADDR_REFDIV:
            if (prog_ok) ref_divider_reg_ff <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Source switch: count edges of the old source with output frozen,
  // then edges of the new one before it may toggle the output
  // A stopped old source would stall here, hence the PLL-on guard
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_src   = src_ff;
    nxt_out   = out_ff;
    case (state_ff)
      ST_RUN: begin
        if (want_src != src_ff) begin
          nxt_state = ST_STOP;
          nxt_cnt   = 2'h0;
        end else if (old_rise) begin
          nxt_out = ~out_ff;
        end
      end
      ST_STOP: begin
        if (old_rise) nxt_cnt = cnt_ff + 2'h1;
        if (cnt_ff == `PBCS_SWITCH_EDGES) begin
          nxt_state = ST_START;
          nxt_cnt   = 2'h0;
        end
      end
      ST_START: begin
        if (new_rise) nxt_cnt = cnt_ff + 2'h1;
        if (cnt_ff == `PBCS_SWITCH_EDGES) begin
          nxt_state = ST_RUN;
          nxt_src   = ~src_ff;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset high so a source parked high is not taken for a rising edge
      xclk_d_ff <= 1'b1;
      vclk_d_ff <= 1'b1;
      src_ff    <= 1'b0;
      state_ff  <= ST_RUN;
      cnt_ff    <= 2'h0;
      out_ff    <= 1'b0;
      osc_en_ff <= 1'b0;
      pll_en_ff <= 1'b0;
      irq_ff    <= 1'b0;
      eff_mul_ff <= 12'h001;
      eff_div_ff <= 4'h1;
      center_ff <= 32'h00000000;
    end else begin
      xclk_d_ff <= crystal_clock;
      vclk_d_ff <= vco_clock;
      src_ff    <= nxt_src;
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      out_ff    <= nxt_out;
      osc_en_ff <= osc_enable_from_sysint | osc_run_in_stop;
      // PLL power needs its own on bit, a usable range and the system enable
      pll_en_ff <= pll_on_a_ff & ~l_zero & osc_enable_from_sysint;
      irq_ff    <= flag_ff & irqen_ff;
      eff_mul_ff <= zero_as_one(raw_mul);
      // Zero divider is shown as one, like the multiplier
      eff_div_ff <= div_as_one[3:0];
      // Exponent 3 is not guarded; the result just scales by eight
      center_ff <= ({24'h000000, vco_range_select_reg_ff}
                    << vco_range_exponent_field_ff) * `PBCS_FNOM_HZ;
    end
  end

endmodule

/* File: sim/pbcs_asserts.sv */
// Port checker for the base clock selector
`timescale 1ns/10ps
module pbcs_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        osc_enable_from_sysint,
  input wire        osc_run_in_stop,
  input wire        base_clock_out,
  input wire        osc_enable,
  input wire        pll_enable,
  input wire [1:0]  prescaler_exp,
  input wire [1:0]  vco_range_exp,
  input wire [11:0] eff_multiplier,
  input wire [3:0]  eff_ref_divider,
  input wire [31:0] vco_center_hz
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_held;
    $stable(prescaler_exp) && $stable(vco_range_exp) && $stable(eff_multiplier);
  endsequence
  AST_MUL_ONE: assert property (eff_multiplier != 12'h000)
    else $error("multiplier zero");
  AST_DIV_ONE: assert property (eff_ref_divider != 4'h0)
    else $error("divider zero");
  AST_ZERO_L: assert property (vco_center_hz == 32'h0 |-> !pll_enable)
    else $error("pll on with zero range");
  AST_GATE: assert property (!osc_enable_from_sysint |=> !pll_enable)
    else $error("pll not gated");
  // Skips the first edge out of reset, where the register still holds 0
  AST_STOP_RUN: assert property ($past(presetn) |->
    osc_enable == $past(osc_enable_from_sysint | osc_run_in_stop)) else $error("osc enable");
  AST_LOCKED: assert property (pll_enable |=> s_held)
    else $error("fields moved while on");
  AST_CENTER: assert property ($stable(vco_range_exp) [*2] |->
    vco_center_hz % (32'h9600 << vco_range_exp) == 32'h0) else $error("center step");
  AST_DUTY: assert property ($changed(base_clock_out) |=>
    $stable(base_clock_out) [*2]) else $error("base clock too fast");
endmodule

/* File: sim/pbcs_src_model.sv */
// Source clocks and base clock edge counter on the far side
`timescale 1ns/10ps
module pbcs_src_model #(parameter int XP = 8, parameter int VP = 6) (
  input wire   pclk,
  input wire   osc_enable,
  input wire   pll_enable,
  input wire   base_clock_out,
  output logic crystal_clock,
  output logic vco_clock,
  output int   base_rises
);
  int xc;
  int vc;
  bit bq;
  assign crystal_clock = xc < XP / 2;
  assign vco_clock = vc < VP / 2;
  // Sources freeze while gated, as real oscillators would
  always @(posedge pclk) begin
    if (osc_enable) xc <= (xc + 1) % XP;
    if (pll_enable) vc <= (vc + 1) % VP;
    bq <= base_clock_out;
    if (base_clock_out && !bq) base_rises <= base_rises + 1;
  end
endmodule

/* File: sim/tb_pbcs_top.sv */
// Self-checking bench for the base clock selector
`timescale 1ns/10ps
`include "pbcs_defs.vh"
module tb_pbcs_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pll_lock = 1'b0, osc_enable_from_sysint = 1'b1, osc_run_in_stop = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic        er;
  wire         pready, pslverr, base_clock_out, osc_enable, pll_enable, clock_gen_interrupt;
  wire         crystal_clock, vco_clock;
  wire  [1:0]  prescaler_exp, vco_range_exp;
  wire  [11:0] eff_multiplier;
  wire  [3:0]  eff_ref_divider;
  wire  [31:0] prdata, vco_center_hz;
  int          base_rises, n_fail, n_checks;
  pbcs_top pbcs_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock(crystal_clock), .vco_clock(vco_clock), .pll_lock(pll_lock),
    .osc_enable_from_sysint(osc_enable_from_sysint), .osc_run_in_stop(osc_run_in_stop),
    .base_clock_out(base_clock_out), .osc_enable(osc_enable), .pll_enable(pll_enable),
    .clock_gen_interrupt(clock_gen_interrupt), .prescaler_exp(prescaler_exp),
    .vco_range_exp(vco_range_exp), .eff_multiplier(eff_multiplier),
    .eff_ref_divider(eff_ref_divider), .vco_center_hz(vco_center_hz)
  );
  pbcs_src_model pbcs_src_model_i (
    .pclk(pclk), .osc_enable(osc_enable), .pll_enable(pll_enable),
    .base_clock_out(base_clock_out), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .base_rises(base_rises)
  );
  initial forever #50 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    n_checks++;
    if (sn !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] ex, input string nm);
    apb(1'b0, ad, 32'h0);
    chk(nm, ex, rd);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic t_reset;
    apb(1'b1, `PBCS_ADDR_MULL, 32'h55);
    rdc(`PBCS_ADDR_MULL, 32'h40, "mul_lo locked");
    rdc(`PBCS_ADDR_RANGE, 32'h40, "range");
    rdc(`PBCS_ADDR_REFDIV, 32'h1, "refdiv");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, er);
    chk("center", 32'h40 * 32'h9600, vco_center_hz);
  endtask
  task automatic t_switch;
    int b = base_rises;
    logic v;
    wt(400);
    chk("xtal rate", 32'h1, (base_rises - b) inside {[24:26]});
    apb(1'b1, `PBCS_ADDR_CTRL, 32'h30);
    wt(1);
    v = base_clock_out;
    // Shortest possible switch still spans three crystal edges
    repeat (12) begin
      @(posedge pclk);
      chk("held", v, base_clock_out);
    end
    wt(60);
    b = base_rises;
    wt(400);
    chk("vco rate", 32'h1, (base_rises - b) inside {[32:34]});
    apb(1'b1, `PBCS_ADDR_CTRL, 32'h20);
    wt(60);
  endtask
  task automatic t_irq;
    apb(1'b1, `PBCS_ADDR_CTRL, 32'hA0);
    pll_lock <= 1'b1;
    wt(4);
    chk("irq", 32'h1, clock_gen_interrupt);
    rdc(`PBCS_ADDR_CTRL, 32'hE0, "flag");
    wt(2);
    chk("irq clear", 32'h0, clock_gen_interrupt);
    apb(1'b1, `PBCS_ADDR_CTRL, 32'h20);
    pll_lock <= 1'b0;
    wt(4);
    chk("irq masked", 32'h0, clock_gen_interrupt);
    rdc(`PBCS_ADDR_CTRL, 32'h60, "flag masked");
  endtask
  task automatic t_osc;
    osc_enable_from_sysint <= 1'b0;
    wt(3);
    chk("osc off", 32'h0, osc_enable | pll_enable);
    osc_run_in_stop <= 1'b1;
    wt(3);
    chk("osc in stop", 32'h1, osc_enable);
    osc_enable_from_sysint <= 1'b1;
    osc_run_in_stop <= 1'b0;
    wt(3);
  endtask
  task automatic t_ctrl;
    logic [7:0] wv [6] = '{8'h00, 8'h10, 8'h30, 8'h30, 8'h00, 8'h00};
    // Last clear lands mid-switch, so the PLL must stay on
    logic [7:0] ev [6] = '{8'h00, 8'h00, 8'h20, 8'h30, 8'h20, 8'h20};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `PBCS_ADDR_CTRL, {24'h0, wv[i]});
      rdc(`PBCS_ADDR_CTRL, {24'h0, ev[i]}, "ctrl");
    end
    wt(120);
    apb(1'b1, `PBCS_ADDR_CTRL, 32'h0);
    rdc(`PBCS_ADDR_CTRL, 32'h0, "pll off idle");
    rdc(`PBCS_ADDR_STATUS, 32'h0, "status idle");
  endtask
  task automatic t_zero;
    apb(1'b1, `PBCS_ADDR_MULL, 32'h0);
    apb(1'b1, `PBCS_ADDR_REFDIV, 32'h0);
    apb(1'b1, `PBCS_ADDR_RANGE, 32'h9C);
    apb(1'b1, `PBCS_ADDR_CTRL, 32'h05);
    wt(3);
    chk("prescaler", 32'h1, prescaler_exp);
    chk("range exp", 32'h1, vco_range_exp);
    chk("mult", 32'h1, eff_multiplier);
    chk("refdiv", 32'h1, eff_ref_divider);
    chk("center", (32'h9C << 1) * 32'h9600, vco_center_hz);
    apb(1'b1, `PBCS_ADDR_RANGE, 32'h0);
    apb(1'b1, `PBCS_ADDR_CTRL, 32'h21);
    apb(1'b1, `PBCS_ADDR_CTRL, 32'h31);
    rdc(`PBCS_ADDR_CTRL, 32'h21, "zero range");
    chk("pll off", 32'h0, pll_enable);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    wt(3);
    presetn <= 1'b1;
    wt(1);
    t_reset;
    t_switch;
    t_irq;
    t_osc;
    t_ctrl;
    t_zero;
    tally_and_finish;
  end
  initial begin
    wt(6000);
    n_fail++;
    tally_and_finish;
  end
endmodule
bind pbcs_top pbcs_asserts pbcs_asserts_i (
  .pclk(pclk), .presetn(presetn), .osc_enable_from_sysint(osc_enable_from_sysint),
  .osc_run_in_stop(osc_run_in_stop), .base_clock_out(base_clock_out),
  .osc_enable(osc_enable), .pll_enable(pll_enable), .prescaler_exp(prescaler_exp),
  .vco_range_exp(vco_range_exp), .eff_multiplier(eff_multiplier),
  .eff_ref_divider(eff_ref_divider), .vco_center_hz(vco_center_hz)
);
